// [fpp_core.sv]
// Four-phase fetch/execute pipeline control with 8-bit ALU datapath
// Function
// [RL1] Clock from fast or slow RC, selected
// [RL2] Four non-overlapping phases from system clock
// [RL3] Phase one: increment PC, start fetch
// [RL4] Phases two to four: decode and execute
// [RL5] Four phases per cycle, fetch overlaps execute
// [RL6] PC-changing instructions take two cycles
// [RL7] Branch: get target, then branch
// [RL8] Eight-bit ALU for all operations
// [RL9] Operands via accumulator; direct/indirect data access
// [RL10] Taken skip discards prefetch, runs dummy cycle
// [RL11] Low-byte PC write jumps in page, dummy
// [RL12] Reset restarts phases, flushes prefetch
`timescale 1ns/100ps
`default_nettype none
module fpp_core
   import fpp_pkg::*;
#(
   parameter int PCW = fpp_pkg::PC_W
) (
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   input  wire logic                  fast_internal_rc_osc,
   input  wire logic                  slow_internal_rc_osc,
   input  wire logic                  clk_sel_slow,
   input  wire logic [INSTR_W-1:0]    prog_rdata,
   input  wire fpp_pkg::fpp_dec_s     dec,
   input  wire logic [DATA_W-1:0]     mem_rdata,
   input  wire logic                  mem_indirect,
   input  wire logic [DATA_W-1:0]     ind_ptr,
   output var  fpp_pkg::fpp_fetch_s   fetch_out,
   output var  logic [INSTR_W-1:0]    exec_instr,
   output var  logic [3:0]            instruction_phase_clocks,
   output var  logic [DATA_W-1:0]     acc,
   output var  logic [DATA_W-1:0]     mem_addr,
   output var  logic [DATA_W-1:0]     program_counter_low_byte,
   output var  logic                  sys_clk_src
);
   import fpp_pkg::*;

   initial begin
      if (PCW != PC_W) $error("fpp_core: PCW must equal PC_W");
   end

   // ==========================================================
   // Oscillator selection
   // ==========================================================
   // The RC oscillators are sampled as pins; the sampled chosen source
   // toggles the phase sequencer. 3-stage sync, change on agreement.
   logic [2:0] fsync_r, fsync_nxt, ssync_r, ssync_nxt;
   logic       fsrc_r, fsrc_nxt, ssrc_r, ssrc_nxt;
   logic       sel_r, sel_nxt, tick_src_r, tick_src_nxt;
   logic       osc_tick;

   always_comb begin
      fsync_nxt = {fsync_r[1:0], fast_internal_rc_osc};
      ssync_nxt = {ssync_r[1:0], slow_internal_rc_osc};
      fsrc_nxt  = (fsync_r[2] == fsync_r[1]) ? fsync_r[2] : fsrc_r;
      ssrc_nxt  = (ssync_r[2] == ssync_r[1]) ? ssync_r[2] : ssrc_r;
      sel_nxt   = clk_sel_slow;
      tick_src_nxt = sel_r ? ssrc_r : fsrc_r;            // RL1
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fsync_r    <= 3'h0;
         ssync_r    <= 3'h0;
         fsrc_r     <= 1'b0;
         ssrc_r     <= 1'b0;
         sel_r      <= 1'b0;
         tick_src_r <= 1'b0;
      end else begin
         fsync_r    <= fsync_nxt;
         ssync_r    <= ssync_nxt;
         fsrc_r     <= fsrc_nxt;
         ssrc_r     <= ssrc_nxt;
         sel_r      <= sel_nxt;
         tick_src_r <= tick_src_nxt;
      end
   end

   // One system clock per rising edge of the chosen source
   assign osc_tick = (sel_r ? ssrc_r : fsrc_r) & ~tick_src_r;  // RL1

   // ==========================================================
   // Phase sequencer
   // ==========================================================
   typedef enum logic [1:0] {
      FPP_RUN, FPP_DUMMY, FPP_BR_TGT
   } fpp_state_e;

   logic [1:0]     ph_r, ph_nxt;
   logic [3:0]     phclk_r, phclk_nxt;
   fpp_state_e     st_r, st_nxt;
   logic [PCW-1:0] pc_r, pc_nxt;
   logic [DATA_W-1:0] acc_r, acc_nxt, maddr_r, maddr_nxt;
   logic           fetch_r, fetch_nxt, first_r, first_nxt;
   logic           ir_load, ir_flush, ir_valid;
   logic [INSTR_W-1:0] ir_data;
   logic           exec_ok;
   logic           cyc_end;

   assign cyc_end = osc_tick && (ph_r == PH_LAST);
   assign exec_ok = ir_valid && (st_r == FPP_RUN) && !first_r;

   function automatic logic [DATA_W-1:0] alu(input fpp_alu_e f,
         input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
      case (f)
         FPP_ALU_ADD: alu = a + b;
         FPP_ALU_SUB: alu = a - b;
         FPP_ALU_AND: alu = a & b;
         FPP_ALU_OR:  alu = a | b;
         FPP_ALU_XOR: alu = a ^ b;
         FPP_ALU_RR:  alu = {a[0], a[DATA_W-1:1]};
         FPP_ALU_INC: alu = a + 8'h01;
         FPP_ALU_DEC: alu = a - 8'h01;
         default:     alu = a;
      endcase
   endfunction

   always_comb begin
      ph_nxt    = ph_r;
      phclk_nxt = phclk_r;
      st_nxt    = st_r;
      pc_nxt    = pc_r;
      acc_nxt   = acc_r;
      maddr_nxt = maddr_r;
      fetch_nxt = 1'b0;
      first_nxt = first_r;
      ir_load   = 1'b0;
      ir_flush  = 1'b0;
      if (osc_tick) begin
         ph_nxt    = ph_r + 2'h1;                        // RL2
         phclk_nxt = 4'h1 << ph_nxt;                     // RL2
         if (ph_nxt == PH_FETCH) begin
            pc_nxt    = pc_r + 11'h001;                  // RL3
            fetch_nxt = 1'b1;                            // RL3
         end
      end
      // Decode on phase two, execute at the end of phase four
      if (osc_tick && ph_r == 2'h1 && exec_ok) begin    // RL4
         maddr_nxt = mem_indirect ? ind_ptr : dec.operand;  // RL9
      end
      if (cyc_end) begin                                 // RL5
         ir_load   = 1'b1;
         ir_flush  = first_r;                            // RL12
         first_nxt = 1'b0;
         case (st_r)
            FPP_RUN: begin
               if (exec_ok) begin
                  case (dec.op)
                     FPP_OP_ALU:
                        acc_nxt = alu(dec.alu, acc_r, mem_rdata); // RL8 RL9
                     FPP_OP_JUMP: begin
                        pc_nxt   = dec.target;           // RL7
                        ir_flush = 1'b1;                 // RL6
                        st_nxt   = FPP_BR_TGT;           // RL6
                     end
                     FPP_OP_SKIP: begin
                        if ((mem_rdata == 8'h00) == dec.skip_cond_zero) begin
                           ir_flush = 1'b1;              // RL10
                           st_nxt   = FPP_DUMMY;         // RL10
                        end
                     end
                     FPP_OP_PCL_WR: begin
                        pc_nxt   = {pc_r[PCW-1:DATA_W], acc_r};  // RL11
                        ir_flush = 1'b1;                 // RL11
                        st_nxt   = FPP_BR_TGT;           // RL11
                     end
                     default: ;
                  endcase
               end
            end
            // Both fetch the right word; its load at the end is kept
            FPP_BR_TGT: st_nxt = FPP_RUN;                // RL7
            FPP_DUMMY:  st_nxt = FPP_RUN;                // RL10
            default: st_nxt = FPP_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_r    <= PH_LAST;                             // RL12
         phclk_r <= 4'h0;
         st_r    <= FPP_RUN;
         pc_r    <= PC_RESET - 11'h001;
         acc_r   <= 8'h00;
         maddr_r <= 8'h00;
         fetch_r <= 1'b0;
         first_r <= 1'b1;                                // RL12
      end else begin
         ph_r    <= ph_nxt;
         phclk_r <= phclk_nxt;
         st_r    <= st_nxt;
         pc_r    <= pc_nxt;
         acc_r   <= acc_nxt;
         maddr_r <= maddr_nxt;
         fetch_r <= fetch_nxt;
         first_r <= first_nxt;
      end
   end

   fpp_ireg #(.WIDTH(INSTR_W)) u_ireg (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .load    (ir_load),
      .flush   (ir_flush),
      .wdata   (prog_rdata),
      .rdata   (ir_data),
      .valid   (ir_valid)
   );

   logic [INSTR_W-1:0] exec_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) exec_r <= NOP_INSTR;
      else         exec_r <= exec_ok ? ir_data : NOP_INSTR;
   end

   assign fetch_out       = '{fetch: fetch_r, addr: pc_r};
   assign exec_instr      = exec_r;
   assign instruction_phase_clocks = phclk_r;
   assign acc             = acc_r;
   assign mem_addr        = maddr_r;
   assign program_counter_low_byte = pc_r[DATA_W-1:0];
   assign sys_clk_src     = sel_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   property p_onehot;
      @(posedge ref_clk) disable iff (!arst_n)
      phclk_r != 4'h0 |-> $onehot(phclk_r);
   endproperty
   a_onehot: assert property (p_onehot)                  // RL2
      else $error("phase clocks overlap");

   property p_pc_inc;
      @(posedge ref_clk) disable iff (!arst_n)
      (cyc_end && !(exec_ok && (dec.op == FPP_OP_JUMP ||
                                dec.op == FPP_OP_PCL_WR)))
         |=> pc_r == $past(pc_r) + 11'h001 && fetch_r;
   endproperty
   a_pc_inc: assert property (p_pc_inc)                  // RL3
      else $error("pc not incremented at phase one");

   property p_ph_step;
      @(posedge ref_clk) disable iff (!arst_n)
      osc_tick |=> ph_r == $past(ph_r) + 2'h1;
   endproperty
   a_ph_step: assert property (p_ph_step)                // RL5
      else $error("phase did not advance");

   property p_br_two;
      @(posedge ref_clk) disable iff (!arst_n)
      (cyc_end && st_r == FPP_BR_TGT) |=> st_r == FPP_RUN && ir_valid;
   endproperty
   a_br_two: assert property (p_br_two)                  // RL6
      else $error("branch second cycle missing");

   property p_br_tgt;
      @(posedge ref_clk) disable iff (!arst_n)
      (cyc_end && exec_ok && dec.op == FPP_OP_JUMP)
         |=> pc_r == $past(dec.target) && st_r == FPP_BR_TGT && !ir_valid;
   endproperty
   a_br_tgt: assert property (p_br_tgt)                  // RL7
      else $error("branch target not loaded");

   property p_dummy;
      @(posedge ref_clk) disable iff (!arst_n)
      (cyc_end && exec_ok && dec.op == FPP_OP_SKIP &&
       (mem_rdata == 8'h00) == dec.skip_cond_zero)
         |=> !ir_valid && st_r == FPP_DUMMY;
   endproperty
   a_dummy: assert property (p_dummy)                    // RL10
      else $error("dummy cycle did not flush");

   property p_pcl_page;
      @(posedge ref_clk) disable iff (!arst_n)
      (cyc_end && exec_ok && dec.op == FPP_OP_PCL_WR)
         |=> pc_r == {$past(pc_r[PCW-1:DATA_W]), $past(acc_r)};
   endproperty
   a_pcl_page: assert property (p_pcl_page)              // RL11
      else $error("low byte write left page");

   property p_no_exec;
      @(posedge ref_clk) disable iff (!arst_n)
      !exec_ok |=> exec_r == NOP_INSTR;
   endproperty
   a_no_exec: assert property (p_no_exec)                // RL12
      else $error("flushed instruction executed");

   c_jump: cover property (@(posedge ref_clk) disable iff (!arst_n)
      cyc_end && st_r == FPP_BR_TGT);
   c_skip: cover property (@(posedge ref_clk) disable iff (!arst_n)
      cyc_end && exec_ok && dec.op == FPP_OP_SKIP);
   c_slow: cover property (@(posedge ref_clk) disable iff (!arst_n)
      sel_r && osc_tick);
endmodule
`default_nettype wire

// [fpp_pkg.sv]
// Package: constants and types for the four-phase instruction pipeline
package fpp_pkg;
   localparam int PC_W        = 11;
   localparam int INSTR_W     = 16;
   localparam int DATA_W      = 8;
   localparam int NUM_PHASES  = 4;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [15:0] NOP_INSTR = 16'h0000;
   localparam logic [1:0]  PH_FETCH = 2'h0;
   localparam logic [1:0]  PH_LAST  = 2'h3;

   typedef enum logic [2:0] {
      FPP_OP_NOP, FPP_OP_ALU, FPP_OP_JUMP,
      FPP_OP_SKIP, FPP_OP_PCL_WR
   } fpp_op_e;

   typedef enum logic [2:0] {
      FPP_ALU_ADD, FPP_ALU_SUB, FPP_ALU_AND, FPP_ALU_OR,
      FPP_ALU_XOR, FPP_ALU_RR, FPP_ALU_INC, FPP_ALU_DEC
   } fpp_alu_e;

   // Decoded instruction as presented by the decoder outside the block
   typedef struct packed {
      fpp_op_e   op;
      fpp_alu_e  alu;
      logic [7:0]  operand;
      logic [10:0] target;
      logic        skip_cond_zero;
   } fpp_dec_s;

   typedef struct packed {
      logic        fetch;
      logic [10:0] addr;
   } fpp_fetch_s;
endpackage

// [fpp_ireg.sv]
// Prefetch instruction register with registered read data
`timescale 1ns/100ps
`default_nettype none
module fpp_ireg #(
   parameter int WIDTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic             load,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] wdata,
   output var  logic [WIDTH-1:0] rdata,
   output var  logic             valid
);
   logic [WIDTH-1:0] data_r, data_nxt;
   logic             vld_r, vld_nxt;

   initial begin
      if (WIDTH < 1) $error("fpp_ireg: WIDTH must be positive");
   end

   always_comb begin
      data_nxt = data_r;
      vld_nxt  = vld_r;
      // A flush beats a load so a squashed fetch never reaches execute
      if (flush) begin
         data_nxt = '0;
         vld_nxt  = 1'b0;
      end else if (load) begin
         data_nxt = wdata;
         vld_nxt  = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_r <= '0;
         vld_r  <= 1'b0;
      end else begin
         data_r <= data_nxt;
         vld_r  <= vld_nxt;
      end
   end

   assign rdata = data_r;
   assign valid = vld_r;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the four-phase pipeline core
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fpp_pkg::*;
   // ============================================================
   // Stimulus and clocks
   logic          ref_clk;
   logic          arst_n;
   logic          clk_sel_slow;
   logic          mem_indirect;
   logic [7:0]    mem_rdata;
   logic [7:0]    ind_ptr;
   logic [3:0]    osc_cnt;
   logic [15:0]   prog_rdata;
   fpp_dec_s      dec;
   fpp_fetch_s    fetch_out;
   logic [15:0]   exec_instr;
   logic [3:0]    instruction_phase_clocks;
   logic [7:0]    acc;
   logic [7:0]    mem_addr;
   logic [7:0]    program_counter_low_byte;
   logic          sys_clk_src;
   int            err_count;
   int            check_count;
   int            cyc;

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Oscillators well below ref_clk/4 so every edge is seen
   initial osc_cnt = 4'h0;
   always @(posedge ref_clk) osc_cnt <= #1 osc_cnt + 4'h1;
   // Each word carries its own address, so a stray execute is visible
   assign prog_rdata = {5'h10, fetch_out.addr};

   fpp_core u_fpp_core (
      .ref_clk                  (ref_clk),
      .arst_n                   (arst_n),
      .fast_internal_rc_osc     (osc_cnt[2]),
      .slow_internal_rc_osc     (osc_cnt[3]),
      .clk_sel_slow             (clk_sel_slow),
      .prog_rdata               (prog_rdata),
      .dec                      (dec),
      .mem_rdata                (mem_rdata),
      .mem_indirect             (mem_indirect),
      .ind_ptr                  (ind_ptr),
      .fetch_out                (fetch_out),
      .exec_instr               (exec_instr),
      .instruction_phase_clocks (instruction_phase_clocks),
      .acc                      (acc),
      .mem_addr                 (mem_addr),
      .program_counter_low_byte (program_counter_low_byte),
      .sys_clk_src              (sys_clk_src)
   );

   // ============================================================
   // Shared tasks
   function automatic logic [15:0] word_of(input logic [10:0] a);
      return {5'h10, a};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic set_dec(input fpp_op_e op, input logic [7:0] o,
                          input logic [10:0] t, input logic z);
      dec = '{op: op, alu: FPP_ALU_ADD, operand: o, target: t,
              skip_cond_zero: z};
   endtask

   task automatic wait_fetch(output logic [10:0] a, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (fetch_out.fetch !== 1'b1 && n < 300);
      chk({15'h0, n < 300}, 16'h0001, "fetch pulse");
      chk({12'h0, instruction_phase_clocks}, 16'h0001, "fetch phase");
      a = fetch_out.addr;
      #1;
   endtask

   task automatic wait_ph(input logic [3:0] m);
      int n = 0;
      while (instruction_phase_clocks !== m && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      chk({12'h0, instruction_phase_clocks}, {12'h0, m}, "phase");
      #1;
   endtask

   // ============================================================
   // Scenarios
   task automatic do_reset;
      logic [10:0] a;
      int          n;
      arst_n = 1'b0;
      set_dec(FPP_OP_NOP, 8'h00, 11'h000, 1'b0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({12'h0, instruction_phase_clocks}, 16'h0000, "rst phase");
      chk({5'h0, fetch_out.addr}, 16'h07FF, "rst pc");
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      wait_fetch(a, n);
      chk({5'h0, a}, 16'h0000, "first fetch");
      wait_ph(4'b0100);
      chk(exec_instr, 16'h0000, "flushed first");
      $display("test reset done");
   endtask

   task automatic t_phase;
      logic [10:0] a;
      logic [10:0] b;
      int          n;
      wait_fetch(a, n);
      wait_ph(4'b0010);
      wait_ph(4'b0100);
      chk(exec_instr, word_of(a - 11'h001), "overlap");
      wait_ph(4'b1000);
      wait_fetch(b, n);
      chk({5'h0, b}, {5'h0, a + 11'h001}, "pc step");
      wait_fetch(b, n);
      chk(16'(n), 16'h0020, "cycle length");
      $display("test phase done");
   endtask

   task automatic t_clk_sel;
      logic [10:0] a;
      int          n;
      clk_sel_slow = 1'b1;
      repeat (4) wait_fetch(a, n);
      chk(16'(n), 16'h0040, "slow cycle");
      chk({15'h0, sys_clk_src}, 16'h0001, "slow src");
      clk_sel_slow = 1'b0;
      repeat (4) wait_fetch(a, n);
      chk(16'(n), 16'h0020, "fast cycle");
      chk({15'h0, sys_clk_src}, 16'h0000, "fast src");
      $display("test clock select done");
   endtask

   task automatic t_alu;
      logic [10:0] a;
      int          n;
      wait_fetch(a, n);
      mem_rdata = 8'h90;
      set_dec(FPP_OP_ALU, 8'h90, 11'h000, 1'b0);
      wait_ph(4'b0100);
      chk({8'h0, mem_addr}, 16'h0090, "direct addr");
      wait_fetch(a, n);
      mem_indirect = 1'b1;
      ind_ptr = 8'h3C;
      wait_ph(4'b0100);
      chk({8'h0, acc}, 16'h0090, "acc add");
      chk({8'h0, mem_addr}, 16'h003C, "indirect addr");
      wait_fetch(a, n);
      set_dec(FPP_OP_NOP, 8'h00, 11'h000, 1'b0);
      mem_indirect = 1'b0;
      wait_ph(4'b0100);
      chk({8'h0, acc}, 16'h0020, "acc wrap");
      $display("test alu done");
   endtask

   task automatic t_skip;
      logic [10:0] a;
      logic [10:0] b;
      int          n;
      logic [7:0]  rd [3] = '{8'h00, 8'h01, 8'h05};
      logic        zc [3] = '{1'b1, 1'b1, 1'b0};
      logic        tk [3] = '{1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 3; i++) begin
         wait_fetch(a, n);
         mem_rdata = rd[i];
         set_dec(FPP_OP_SKIP, 8'h00, 11'h000, zc[i]);
         wait_fetch(b, n);
         set_dec(FPP_OP_NOP, 8'h00, 11'h000, 1'b0);
         wait_ph(4'b0100);
         chk(exec_instr, tk[i] ? 16'h0000 : word_of(a), "skip slot");
         wait_fetch(a, n);
         wait_ph(4'b0100);
         chk(exec_instr, word_of(b), "after skip");
      end
      $display("test skip done");
   endtask

   task automatic t_branch(input fpp_op_e op, input logic [10:0] tg);
      logic [10:0] a;
      logic [10:0] b;
      logic [10:0] t;
      int          n;
      wait_fetch(a, n);
      t = (op == FPP_OP_JUMP) ? tg : {a[10:8], 8'h20};
      set_dec(op, 8'h00, tg, 1'b0);
      // The very next cycle must already fetch the target
      wait_fetch(b, n);
      set_dec(FPP_OP_NOP, 8'h00, 11'h000, 1'b0);
      wait_ph(4'b0100);
      chk(exec_instr, 16'h0000, "branch squash");
      chk({5'h0, b}, {5'h0, t}, "branch target");
      if (op == FPP_OP_PCL_WR) chk({8'h0, program_counter_low_byte},
                                   16'h0020, "pc low byte");
      wait_fetch(b, n);
      wait_ph(4'b0100);
      chk(exec_instr, word_of(t), "target runs");
      $display("test branch done");
   endtask

   // ============================================================
   // Main sequence and hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      logic [10:0] a;
      int          n;
      arst_n = 1'b0;
      clk_sel_slow = 1'b0;
      mem_indirect = 1'b0;
      mem_rdata = 8'h00;
      ind_ptr = 8'h00;
      set_dec(FPP_OP_NOP, 8'h00, 11'h000, 1'b0);
      err_count = 0;
      check_count = 0;
      #1;
      do_reset();
      t_phase();
      t_clk_sel();
      t_alu();
      t_skip();
      t_branch(FPP_OP_JUMP, 11'h2A5);
      t_branch(FPP_OP_PCL_WR, 11'h000);
      // Reset lands in phase three, after a jump is decoded and before it executes
      wait_fetch(a, n);
      set_dec(FPP_OP_JUMP, 8'h00, 11'h155, 1'b0);
      wait_ph(4'b0100);
      do_reset();
      t_phase();
      end_of_test();
   end
endmodule
`default_nettype wire
